/* core/gfcc_regs.vh */
// Register map, field positions, reset values and timing for the pin and alarm-chain block
`ifndef GFCC_REGS_VH
`define GFCC_REGS_VH

// Word addresses on the register port
`define GFCC_A_FUNC        8'h00
`define GFCC_A_DRIVE       8'h01
`define GFCC_A_LEVEL       8'h02
`define GFCC_A_SHORT       8'h03
`define GFCC_A_MASK        8'h04
`define GFCC_A_SYS1        8'h05
`define GFCC_A_SUM1        8'h06
`define GFCC_A_SUM2        8'h07
`define GFCC_B_OT          5'h02
`define GFCC_B_UT          5'h03
`define GFCC_B_RES         5'h04
`define GFCC_IDX_NONE      3'h7

// Pin function field codes
`define GFCC_FN_RATIO      2'h0
`define GFCC_FN_ABS        2'h1
`define GFCC_FN_DIN        2'h2
`define GFCC_FN_DOUT       2'h3

// Field positions
`define GFCC_DRV_WAKE      7
`define GFCC_DRV_CHAIN     8
`define GFCC_DRV_TRIG      9
`define GFCC_SYS_HB_EN     0
`define GFCC_SYS_HB_OFF_LO 1
`define GFCC_SYS_HB_OFF_HI 2
`define GFCC_SYS_SOC       3
`define GFCC_MSK_OT        7
`define GFCC_MSK_UT        8
`define GFCC_SUM1_OT       0
`define GFCC_SUM1_UT       1
`define GFCC_PIN_ZERO      0
`define GFCC_PIN_TWO       2

// Reset values
`define GFCC_RST_FUNC      14'h0000
`define GFCC_RST_DRIVE     10'h000
`define GFCC_RST_MASK      9'h000
`define GFCC_RST_SYS1      3'h0
`define GFCC_RST_OT_TH     16'h0000
`define GFCC_RST_UT_TH     16'hffff

// Operating modes
`define GFCC_MODE_SLEEP    2'h1

// Timing
`define GFCC_CLK_MHZ       200
`define GFCC_SETTLE_CYC    3'h4
`define GFCC_HB_ON_US      10
`define GFCC_HB_OFF0_US    20
`define GFCC_HB_OFF1_US    40
`define GFCC_HB_OFF2_US    80
`define GFCC_HB_OFF3_US    160

`endif

/* core/gfcc_sync.v */
// Two-stage synchroniser for a group of pin inputs
`timescale 1ns/100ps
module gfcc_sync #(
    parameter W = 7
) (
    input  wire         clk_sys_in,
    input  wire         arst_n_in,
    input  wire [W-1:0] async_in,
    output wire [W-1:0] sync_out
);
    reg [W-1:0] meta_r;
    reg [W-1:0] sync_r;

    always @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            meta_r <= {W{1'b0}};
            sync_r <= {W{1'b0}};
        end else begin
            meta_r <= async_in;
            sync_r <= meta_r;
        end
    end

    assign sync_out = sync_r;
endmodule // gfcc_sync

/* core/gfcc_top.v */
// General-purpose pin control, short detection, temperature checks and alarm chain output
//
// Chosen here: the strobed register port and the address map.
`timescale 1ns/100ps
`include "gfcc_regs.vh"
module gfcc_top #(
    parameter [15:0] HB_ON_CYC   = `GFCC_HB_ON_US * `GFCC_CLK_MHZ,
    parameter [15:0] HB_OFF0_CYC = `GFCC_HB_OFF0_US * `GFCC_CLK_MHZ,
    parameter [15:0] HB_OFF1_CYC = `GFCC_HB_OFF1_US * `GFCC_CLK_MHZ,
    parameter [15:0] HB_OFF2_CYC = `GFCC_HB_OFF2_US * `GFCC_CLK_MHZ,
    parameter [15:0] HB_OFF3_CYC = `GFCC_HB_OFF3_US * `GFCC_CLK_MHZ
) (
    input  wire        clk_sys_in,
    input  wire        arst_n_in,
    input  wire [7:0]  reg_addr_in,
    input  wire [15:0] reg_wdata_in,
    input  wire        reg_wr_in,
    input  wire        reg_rd_in,
    output wire [15:0] reg_rdata_out,
    input  wire [6:0]  pin_in,
    output wire [6:0]  pin_out,
    output wire [6:0]  pin_oe_n_out,
    input  wire [1:0]  op_mode_in,
    input  wire        conv_valid_in,
    input  wire [2:0]  conv_chan_in,
    input  wire [15:0] conv_data_in,
    output wire        conv_start_out,
    output wire        wake_out,
    output wire        alarm_pin_out
);
    localparam HB_HIGH = 1'b0;
    localparam HB_LOW  = 1'b1;

    // Register state
    reg  [13:0] pin_function_config_r;
    reg  [9:0]  pin_drive_control_r;
    reg  [6:0]  short_open_status_r;
    reg  [8:0]  fault_mask_r;
    reg  [2:0]  system_config_one_r;
    reg  [1:0]  alarm_summary_one_r;
    reg  [15:0] over_temp_threshold_r [0:6];
    reg  [15:0] under_temp_threshold_r [0:6];
    reg  [15:0] analog_result_r [0:6];
    reg  [15:0] reg_rdata_r;
    reg  [15:0] rdata_nxt;

    // Pin path state
    wire [6:0]  pin_sync;
    reg  [6:0]  pin_prev_r;
    reg  [2:0]  settle_r;
    reg         conv_start_r;
    reg         wake_r;

    // Heartbeat and alarm state
    reg         hb_state_r;
    reg  [15:0] hb_cnt_r;
    reg         alarm_r;
    reg         alarm_nxt;
    reg  [15:0] hb_off_cyc;

    reg  [6:0]  is_out;
    reg  [6:0]  is_ana;
    reg  [6:0]  short_set;
    reg  [6:0]  short_clr;
    reg  [1:0]  temp_set;
    reg  [1:0]  temp_clr;
    integer     i;
    integer     j;

    wire [2:0]  reg_idx = reg_addr_in[2:0];
    wire [4:0]  reg_base = reg_addr_in[7:3];
    wire        idx_ok = (reg_idx != `GFCC_IDX_NONE);
    wire        hb_en = system_config_one_r[`GFCC_SYS_HB_EN];
    wire [1:0]  hb_off_sel = system_config_one_r[`GFCC_SYS_HB_OFF_HI:`GFCC_SYS_HB_OFF_LO];
    wire        wake_en = pin_drive_control_r[`GFCC_DRV_WAKE];
    wire        chain_alarm_enable = pin_drive_control_r[`GFCC_DRV_CHAIN];
    wire        ext_trigger_enable = pin_drive_control_r[`GFCC_DRV_TRIG];
    wire        pin_short_summary = |short_open_status_r;
    wire        wr_cfg = reg_wr_in & ((reg_addr_in == `GFCC_A_FUNC) |
                                      (reg_addr_in == `GFCC_A_DRIVE));
    wire        sw_soc = reg_wr_in & (reg_addr_in == `GFCC_A_SYS1) &
                         reg_wdata_in[`GFCC_SYS_SOC];
    wire [1:0]  conv_fn = pin_fn(pin_function_config_r, conv_chan_in);
    wire        conv_ana = conv_valid_in & (conv_chan_in != `GFCC_IDX_NONE) &
                           (conv_fn[1] == 1'b0);

    // Two bits per pin, pin n at bits 2n+1:2n
    function [1:0] pin_fn;
        input [13:0] cfg;
        input [2:0]  idx;
        begin
            pin_fn = cfg[{idx, 1'b0} +: 2];
        end
    endfunction

    // Pins arrive from the board, so nothing reads them before two stages
    gfcc_sync #(
        .W (7)
    ) u_pin_sync (
        .clk_sys_in (clk_sys_in),
        .arst_n_in  (arst_n_in),
        .async_in   (pin_in),
        .sync_out   (pin_sync)
    );

    // Per-pin role decode
    always @* begin
        for (i = 0; i < 7; i = i + 1) begin
            is_out[i] = (pin_fn(pin_function_config_r, i[2:0]) == `GFCC_FN_DOUT);
            is_ana[i] = (pin_fn(pin_function_config_r, i[2:0]) == `GFCC_FN_RATIO) |
                        (pin_fn(pin_function_config_r, i[2:0]) == `GFCC_FN_ABS);
        end
    end

    // Pins drive only as outputs; everything else is released
    assign pin_out      = pin_drive_control_r[6:0];
    assign pin_oe_n_out = ~is_out;

    // Short check blanked while a new drive value crosses the synchroniser
    always @* begin
        short_set = {7{1'b0}};
        if (settle_r == 3'h0) begin
            short_set = is_out & (pin_sync ^ pin_drive_control_r[6:0]);
        end
        short_clr = {7{1'b0}};
        if (reg_wr_in && (reg_addr_in == `GFCC_A_SHORT)) begin
            short_clr = reg_wdata_in[6:0];
        end
    end

    // Temperature comparisons on fresh analog results
    always @* begin
        temp_set = 2'h0;
        if (conv_ana) begin
            if (conv_data_in < over_temp_threshold_r[conv_chan_in]) begin
                temp_set[`GFCC_SUM1_OT] = 1'b1;
            end
            if (conv_data_in > under_temp_threshold_r[conv_chan_in]) begin
                temp_set[`GFCC_SUM1_UT] = 1'b1;
            end
        end
        temp_clr = 2'h0;
        if (reg_wr_in && (reg_addr_in == `GFCC_A_SUM1)) begin
            temp_clr = reg_wdata_in[1:0];
        end
    end

    // Register writes and sticky flags; a set in the clear cycle wins
    always @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pin_function_config_r <= `GFCC_RST_FUNC;
            pin_drive_control_r   <= `GFCC_RST_DRIVE;
            fault_mask_r          <= `GFCC_RST_MASK;
            system_config_one_r   <= `GFCC_RST_SYS1;
            short_open_status_r   <= 7'h00;
            alarm_summary_one_r   <= 2'h0;
            settle_r              <= `GFCC_SETTLE_CYC;
            for (j = 0; j < 7; j = j + 1) begin
                over_temp_threshold_r[j]  <= `GFCC_RST_OT_TH;
                under_temp_threshold_r[j] <= `GFCC_RST_UT_TH;
                analog_result_r[j]        <= 16'h0000;
            end
        end else begin
            if (reg_wr_in) begin
                case (reg_addr_in)
                    `GFCC_A_FUNC:  pin_function_config_r <= reg_wdata_in[13:0];
                    `GFCC_A_DRIVE: pin_drive_control_r   <= reg_wdata_in[9:0];
                    `GFCC_A_MASK:  fault_mask_r          <= reg_wdata_in[8:0];
                    `GFCC_A_SYS1:  system_config_one_r   <= reg_wdata_in[2:0];
                    default: begin
                    end
                endcase
                if (idx_ok && (reg_base == `GFCC_B_OT)) begin
                    over_temp_threshold_r[reg_idx] <= reg_wdata_in;
                end
                if (idx_ok && (reg_base == `GFCC_B_UT)) begin
                    under_temp_threshold_r[reg_idx] <= reg_wdata_in;
                end
            end
            if (wr_cfg) begin
                settle_r <= `GFCC_SETTLE_CYC;
            end else if (settle_r != 3'h0) begin
                settle_r <= settle_r - 3'h1;
            end
            short_open_status_r <= (short_open_status_r & ~short_clr) | short_set;
            alarm_summary_one_r <= (alarm_summary_one_r & ~temp_clr) | temp_set;
            if (conv_ana) begin
                analog_result_r[conv_chan_in] <= conv_data_in;
            end
        end
    end

    // Edge events on synchronised pins
    always @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pin_prev_r   <= 7'h00;
            conv_start_r <= 1'b0;
            wake_r       <= 1'b0;
        end else begin
            pin_prev_r <= pin_sync;
            // Pin and software starts share one request, so one set of converter settings
            conv_start_r <= sw_soc |
                            ((pin_fn(pin_function_config_r, `GFCC_PIN_TWO) == `GFCC_FN_DIN) &
                             ext_trigger_enable & (op_mode_in != `GFCC_MODE_SLEEP) &
                             pin_sync[`GFCC_PIN_TWO] & ~pin_prev_r[`GFCC_PIN_TWO]);
            wake_r <= (pin_fn(pin_function_config_r, `GFCC_PIN_ZERO) == `GFCC_FN_DIN) &
                      wake_en &
                      (pin_sync[`GFCC_PIN_ZERO] ^ pin_prev_r[`GFCC_PIN_ZERO]);
        end
    end

    assign conv_start_out = conv_start_r;
    assign wake_out       = wake_r;

    // Heartbeat low time
    always @* begin
        case (hb_off_sel)
            2'h0:    hb_off_cyc = HB_OFF0_CYC;
            2'h1:    hb_off_cyc = HB_OFF1_CYC;
            2'h2:    hb_off_cyc = HB_OFF2_CYC;
            default: hb_off_cyc = HB_OFF3_CYC;
        endcase
    end

    // Heartbeat generator; idles in the high phase when disabled
    always @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            hb_state_r <= HB_HIGH;
            hb_cnt_r   <= 16'h0000;
        end else if (!hb_en) begin
            hb_state_r <= HB_HIGH;
            hb_cnt_r   <= 16'h0000;
        end else begin
            case (hb_state_r)
                HB_HIGH: begin
                    if (hb_cnt_r >= HB_ON_CYC - 16'h0001) begin
                        hb_state_r <= HB_LOW;
                        hb_cnt_r   <= 16'h0000;
                    end else begin
                        hb_cnt_r <= hb_cnt_r + 16'h0001;
                    end
                end
                HB_LOW: begin
                    if (hb_cnt_r >= hb_off_cyc - 16'h0001) begin
                        hb_state_r <= HB_HIGH;
                        hb_cnt_r   <= 16'h0000;
                    end else begin
                        hb_cnt_r <= hb_cnt_r + 16'h0001;
                    end
                end
                default: begin
                    hb_state_r <= HB_HIGH;
                    hb_cnt_r   <= 16'h0000;
                end
            endcase
        end
    end

    // Alarm pin; no operating-mode gating, so both styles run in every mode
    wire local_fault = |(short_open_status_r & ~fault_mask_r[6:0]) |
                       (alarm_summary_one_r[`GFCC_SUM1_OT] & ~fault_mask_r[`GFCC_MSK_OT]) |
                       (alarm_summary_one_r[`GFCC_SUM1_UT] & ~fault_mask_r[`GFCC_MSK_UT]);

    always @* begin
        if (!hb_en) begin
            alarm_nxt = local_fault |
                        (chain_alarm_enable & pin_sync[`GFCC_PIN_ZERO]);
        end else if (local_fault) begin
            // A local fault stops the wave: held high
            alarm_nxt = 1'b1;
        end else if (chain_alarm_enable) begin
            alarm_nxt = pin_sync[`GFCC_PIN_ZERO];
        end else begin
            alarm_nxt = (hb_state_r == HB_HIGH);
        end
    end

    always @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            alarm_r <= 1'b0;
        end else begin
            alarm_r <= alarm_nxt;
        end
    end

    assign alarm_pin_out = alarm_r;

    // Read mux; unmapped addresses read zero
    always @* begin
        rdata_nxt = 16'h0000;
        case (reg_addr_in)
            `GFCC_A_FUNC:  rdata_nxt = {2'h0, pin_function_config_r};
            `GFCC_A_DRIVE: rdata_nxt = {6'h00, pin_drive_control_r};
            `GFCC_A_LEVEL: rdata_nxt = {9'h000, pin_sync};
            `GFCC_A_SHORT: rdata_nxt = {9'h000, short_open_status_r};
            `GFCC_A_MASK:  rdata_nxt = {7'h00, fault_mask_r};
            `GFCC_A_SYS1:  rdata_nxt = {13'h0000, system_config_one_r};
            `GFCC_A_SUM1:  rdata_nxt = {14'h0000, alarm_summary_one_r};
            `GFCC_A_SUM2:  rdata_nxt = {15'h0000, pin_short_summary};
            default: begin
                if (idx_ok && (reg_base == `GFCC_B_OT)) begin
                    rdata_nxt = over_temp_threshold_r[reg_idx];
                end else if (idx_ok && (reg_base == `GFCC_B_UT)) begin
                    rdata_nxt = under_temp_threshold_r[reg_idx];
                end else if (idx_ok && (reg_base == `GFCC_B_RES)) begin
                    rdata_nxt = analog_result_r[reg_idx];
                end
            end
        endcase
    end

    // Data stands only in the cycle after the read strobe
    always @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            reg_rdata_r <= 16'h0000;
        end else if (reg_rd_in) begin
            reg_rdata_r <= rdata_nxt;
        end else begin
            reg_rdata_r <= 16'h0000;
        end
    end

    assign reg_rdata_out = reg_rdata_r;
endmodule // gfcc_top

/* dv/gfcc_monitor.sv */
// Port-level assertions for the pin and alarm-chain block
`timescale 1ns/100ps
`include "gfcc_regs.vh"
module gfcc_monitor (
    input wire        clk_sys_in,
    input wire        arst_n_in,
    input wire [7:0]  reg_addr_in,
    input wire [15:0] reg_wdata_in,
    input wire        reg_wr_in,
    input wire        reg_rd_in,
    input wire [15:0] reg_rdata_out,
    input wire [6:0]  pin_in,
    input wire [6:0]  pin_out,
    input wire [6:0]  pin_oe_n_out,
    input wire [1:0]  op_mode_in,
    input wire        conv_start_out,
    input wire        wake_out,
    input wire        alarm_pin_out
);
    reg chain_r;

    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!arst_n_in);

    function automatic [6:0] gfcc_oe_of(input [15:0] w);
        integer i;
        for (i = 0; i < 7; i = i + 1)
            gfcc_oe_of[i] = (w[2*i +: 2] != `GFCC_FN_DOUT);
    endfunction

    // Shadow of the chain enable; the block hides it behind the bus
    always @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in)
            chain_r <= 1'b0;
        else if (reg_wr_in && reg_addr_in == `GFCC_A_DRIVE)
            chain_r <= reg_wdata_in[`GFCC_DRV_CHAIN];
    end

    property p_oe;
        reg_wr_in && reg_addr_in == `GFCC_A_FUNC |=>
            pin_oe_n_out == gfcc_oe_of($past(reg_wdata_in));
    endproperty
    a_oe: assert property (p_oe)
        else $error("output enable wrong");
    property p_drive;
        reg_wr_in && reg_addr_in == `GFCC_A_DRIVE |=> pin_out == $past(reg_wdata_in[6:0]);
    endproperty
    a_drive: assert property (p_drive)
        else $error("pin drive wrong");
    // Pins held still so synchroniser delay cannot blur the value
    property p_level;
        $stable(pin_in)[*4] ##0 (reg_rd_in && reg_addr_in == `GFCC_A_LEVEL) |=>
            reg_rdata_out == {9'h000, $past(pin_in)};
    endproperty
    a_level: assert property (p_level)
        else $error("pin level read wrong");
    property p_wake;
        wake_out |-> $past(pin_in[0], 3) != $past(pin_in[0], 4);
    endproperty
    a_wake: assert property (p_wake)
        else $error("wake without pin edge");
    property p_trig;
        conv_start_out |-> $past(reg_wr_in) || ($past(pin_in[2], 3) && !$past(pin_in[2], 4));
    endproperty
    a_trig: assert property (p_trig)
        else $error("start without cause");
    property p_sleep;
        (op_mode_in == `GFCC_MODE_SLEEP)[*5] ##0 !$past(reg_wr_in) |-> !conv_start_out;
    endproperty
    a_sleep: assert property (p_sleep)
        else $error("pin start in sleep");
    property p_soft;
        reg_wr_in && reg_addr_in == `GFCC_A_SYS1 && reg_wdata_in[`GFCC_SYS_SOC] |=>
            conv_start_out;
    endproperty
    a_soft: assert property (p_soft)
        else $error("software start lost");
    property p_chain;
        chain_r && $past(chain_r, 4) && $past(pin_in[0], 3) |-> alarm_pin_out;
    endproperty
    a_chain: assert property (p_chain)
        else $error("chain input not on alarm");
endmodule // gfcc_monitor

bind gfcc_top gfcc_monitor gfcc_monitor_i (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe_n_out(pin_oe_n_out), .op_mode_in(op_mode_in),
    .conv_start_out(conv_start_out), .wake_out(wake_out), .alarm_pin_out(alarm_pin_out));

/* dv/gfcc_pins_model.sv */
// Board side of the seven pins: external sources, and shorts forced on driven pins
`timescale 1ns/100ps
module gfcc_pins_model (
    input  wire [6:0] drv_in,
    input  wire [6:0] oe_n_in,
    input  wire [6:0] ext_in,
    input  wire [6:0] short_in,
    output wire [6:0] level_out
);
    // A short overpowers the driver and shows the opposite level
    assign level_out = (~oe_n_in & (drv_in ^ short_in)) | (oe_n_in & ext_in);
endmodule // gfcc_pins_model

/* dv/testbench.sv */
// Self-checking bench for the pin and alarm-chain block
`timescale 1ns/100ps
`include "gfcc_regs.vh"
module testbench;
    localparam int HB_ON = 4;
    localparam int HB_OFF = 6;
    logic        clk_sys_in = 1'b0;
    logic        arst_n_in = 1'b0;
    logic        reg_wr_in = 1'b0;
    logic        reg_rd_in = 1'b0;
    logic        conv_valid_in = 1'b0;
    logic [7:0]  reg_addr_in = 8'h00;
    logic [15:0] reg_wdata_in = 16'h0000;
    logic [15:0] conv_data_in = 16'h0000;
    logic [2:0]  conv_chan_in = 3'h0;
    logic [1:0]  op_mode_in = 2'h0;
    logic [6:0]  pin_ext = 7'h00;
    logic [6:0]  pin_short = 7'h00;
    wire  [6:0]  pin_in, pin_out, pin_oe_n_out;
    wire  [15:0] reg_rdata_out;
    wire         conv_start_out, wake_out, alarm_pin_out;
    int          miscompares = 0, n_compared = 0, n_wake = 0, n_conv = 0;
    integer      seed = 12573;
    int          mdl [0:63];
    int          q [$];

    always #2.5 clk_sys_in = ~clk_sys_in;
    always @(posedge clk_sys_in) begin
        n_wake <= n_wake + wake_out;
        n_conv <= n_conv + conv_start_out;
    end

    gfcc_top #(.HB_ON_CYC(16'(HB_ON)), .HB_OFF0_CYC(16'(HB_OFF)), .HB_OFF1_CYC(16'(HB_OFF + 2)),
        .HB_OFF2_CYC(16'(HB_OFF + 4)), .HB_OFF3_CYC(16'(HB_OFF + 6))) gfcc_top_i (
        .clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe_n_out(pin_oe_n_out), .op_mode_in(op_mode_in), .conv_valid_in(conv_valid_in),
        .conv_chan_in(conv_chan_in), .conv_data_in(conv_data_in),
        .conv_start_out(conv_start_out), .wake_out(wake_out), .alarm_pin_out(alarm_pin_out));
    gfcc_pins_model gfcc_pins_model_i (.drv_in(pin_out), .oe_n_in(pin_oe_n_out),
        .ext_in(pin_ext), .short_in(pin_short), .level_out(pin_in));

    task results;
        if (miscompares == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clk_sys_in);
    endtask
    task wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_sys_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge clk_sys_in);
        reg_wr_in <= 1'b0;
        mdl[a[5:0]] = d;
    endtask
    task rd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clk_sys_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge clk_sys_in);
        reg_rd_in <= 1'b0;
        #1 chk(reg_rdata_out, exp);
    endtask
    // Bounded wait for an alarm level, counting whole cycles
    task wlvl(input logic v, output int n);
        n = 0;
        while (alarm_pin_out !== v) begin
            @(negedge clk_sys_in);
            n++;
            if (n > 200) begin
                miscompares++;
                results;
            end
        end
    endtask

    initial begin
        int c, hi, lo;
        logic [6:0] d;
        logic [15:0] v;
        cyc(20);
        arst_n_in <= 1'b1;
        cyc(4);
        chk({9'h000, pin_oe_n_out}, 16'h007f);
        rd(`GFCC_A_FUNC, 16'h0000);
        rd(8'h18, `GFCC_RST_UT_TH);
        rd(8'h3f, 16'h0000);
        for (int s = 0; s < 4; s++) begin
            wr(`GFCC_A_SYS1, 16'(1 + 2 * s));
            op_mode_in <= 2'(s % 3);
            wlvl(1'b0, c);
            wlvl(1'b1, c);
            wlvl(1'b0, hi);
            wlvl(1'b1, lo);
            chk(16'(hi), 16'(HB_ON));
            chk(16'(lo), 16'(HB_OFF + 2 * s));
        end
        wr(`GFCC_A_SYS1, 16'h0000);
        wr(`GFCC_A_FUNC, 16'h0002);
        wr(`GFCC_A_DRIVE, 16'h0100);
        for (int m = 0; m < 6; m++) begin
            op_mode_in <= 2'(m % 3);
            if (m == 3)
                wr(`GFCC_A_SYS1, 16'h0001);
            pin_ext[0] <= 1'b1;
            cyc(8);
            chk({15'h0, alarm_pin_out}, 16'h0001);
            pin_ext[0] <= 1'b0;
            cyc(8);
            chk({15'h0, alarm_pin_out}, 16'h0000);
        end
        op_mode_in <= 2'h0;
        wr(`GFCC_A_SYS1, 16'h0000);
        wr(`GFCC_A_FUNC, 16'h3fff);
        for (int k = 0; k < 4; k++) begin
            d = 7'($random(seed));
            wr(`GFCC_A_DRIVE, {9'h000, d});
            cyc(6);
            chk({9'h000, pin_out}, {9'h000, d});
            rd(`GFCC_A_LEVEL, {9'h000, d});
            rd(`GFCC_A_SHORT, 16'h0000);
        end
        rd(`GFCC_A_FUNC, 16'(mdl[0]));
        pin_short <= 7'h08;
        cyc(8);
        rd(`GFCC_A_LEVEL, {9'h000, d ^ 7'h08});
        rd(`GFCC_A_SHORT, 16'h0008);
        rd(`GFCC_A_SUM2, 16'h0001);
        chk({15'h0, alarm_pin_out}, 16'h0001);
        wr(`GFCC_A_MASK, 16'h0008);
        cyc(2);
        chk({15'h0, alarm_pin_out}, 16'h0000);
        pin_short <= 7'h00;
        cyc(6);
        wr(`GFCC_A_SHORT, 16'h007f);
        rd(`GFCC_A_SHORT, 16'h0000);
        rd(`GFCC_A_SUM2, 16'h0000);
        wr(`GFCC_A_FUNC, 16'h0022);
        wr(`GFCC_A_DRIVE, 16'h0280);
        // Releasing pin zero may be a real edge; let its wake pass before counting
        cyc(4);
        for (int k = 0; k < 4; k++) begin
            c = n_wake;
            pin_ext[0] <= ~pin_ext[0];
            cyc(8);
            chk(16'(n_wake - c), 16'h0001);
        end
        for (int k = 0; k < 6; k++) begin
            c = n_conv;
            op_mode_in <= (k > 3) ? `GFCC_MODE_SLEEP : 2'h0;
            pin_ext[2] <= ~pin_ext[2];
            cyc(8);
            chk(16'(n_conv - c), 16'((k < 4 && k % 2 == 0) ? 1 : 0));
        end
        op_mode_in <= 2'h0;
        c = n_conv;
        wr(`GFCC_A_SYS1, 16'h0008);
        cyc(2);
        chk(16'(n_conv - c), 16'h0001);
        wr(`GFCC_A_FUNC, 16'h00c4);
        wr(8'h11, 16'h4000);
        wr(8'h19, 16'hc000);
        for (int k = 0; k < 7; k++) begin
            v = (k == 6) ? 16'hffff : 16'($random(seed));
            @(posedge clk_sys_in);
            conv_valid_in <= 1'b1;
            conv_chan_in <= (k == 6) ? 3'h3 : 3'h1;
            conv_data_in <= v;
            @(posedge clk_sys_in);
            conv_valid_in <= 1'b0;
            if (k < 6)
                q.push_back(v);
            rd(8'h23, 16'h0000);
            rd(8'h21, 16'(q[$]));
            rd(`GFCC_A_SUM1, (k == 6) ? 16'h0000 : {14'h0, v > 16'hc000, v < 16'h4000});
            wr(`GFCC_A_SUM1, 16'h0003);
        end
        rd(8'h11, 16'(mdl[6'h11]));
        results;
    end

    initial begin
        #400000;
        miscompares++;
        results;
    end
endmodule // testbench
